// file: hdl/pcp_client_port.sv
// Parallel client port: external 8-bit microprocessor port on the general data port.
// What this block does
// R1 - Mode bit turns data port into client port unless multi-output PWM runs.
// R2 - External master reads and writes the data latch as one 8-bit latch.
// R3 - Control pins zero, one, two are read strobe, write strobe, chip select.
// R4 - Client functions need the three control direction bits set to input.
// R5 - Analog config field must be 1010 to 1111 for client operation.
// R6 - Strobes are accepted without any shared clock.
// R7 - Write starts when select and write both low, ends when either high.
// R8 - At write end set client interrupt flag and input-full flag.
// R9 - Read starts when select and read both low; drive latch, clear output-full.
// R10 - Software write during read appears at once; output-full stays clear.
// R11 - Read end releases data pins and sets client interrupt flag.
// R12 - Software waits for interrupt flag then polls full flags.
// R13 - Input-full is one while a received word waits for software.
// R14 - Output-full is one while the written word is not yet read externally.
// R15 - Write before previous input was read sets sticky overflow flag.
// R16 - Control strobes synchronised; edges found from synchronised levels.
`timescale 1ns/1ps
`default_nettype none

module pcp_client_port
    import pcp_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic [3:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    output logic      [7:0] o_reg_rdata,
    input  wire logic [7:0] i_data_pins,
    output logic      [7:0] o_data_pins,
    output logic      [7:0] o_data_oe,
    input  wire logic [2:0] i_ctrl_pins,
    output logic      [2:0] o_ctrl_pins,
    output logic      [2:0] o_ctrl_oe,
    output logic            o_irq
);

    // ========================================================================
    // Reset release
    // ========================================================================
    logic rst_meta_reg;
    logic rst_n;

    // Reset enters asynchronously and is released through two flops.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ========================================================================
    // Control pin synchronisers
    // ========================================================================
    logic [2:0] ctl_s1_reg;
    logic [2:0] ctl_s2_reg;
    logic [2:0] ctl_s3_reg;
    logic [2:0] ctl_lvl_reg;
    logic [7:0] din_s1_reg;
    logic [7:0] din_s2_reg;
    logic [7:0] din_s3_reg;
    logic [7:0] din_lvl_reg;

    // Three stages; a level counts once stages two and three agree, which
    // filters a single-cycle glitch at the cost of one extra cycle.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_s1_reg  <= 3'h7;
            ctl_s2_reg  <= 3'h7;
            ctl_s3_reg  <= 3'h7;
            ctl_lvl_reg <= 3'h7;
            din_s1_reg  <= 8'h00;
            din_s2_reg  <= 8'h00;
            din_s3_reg  <= 8'h00;
            din_lvl_reg <= 8'h00;
        end else begin
            ctl_s1_reg <= i_ctrl_pins;  // R6
            ctl_s2_reg <= ctl_s1_reg;   // R16
            ctl_s3_reg <= ctl_s2_reg;
            for (int i = 0; i < 3; i++) begin
                if (ctl_s2_reg[i] == ctl_s3_reg[i]) begin
                    ctl_lvl_reg[i] <= ctl_s3_reg[i];
                end
            end
            din_s1_reg <= i_data_pins;
            din_s2_reg <= din_s1_reg;
            din_s3_reg <= din_s2_reg;
            // A data bit moves only once stages two and three agree.
            din_lvl_reg <= (din_s2_reg & din_s3_reg) | (din_lvl_reg & (din_s2_reg ^ din_s3_reg));
        end
    end

    // ========================================================================
    // Configuration registers
    // ========================================================================
    logic [7:0] latch_reg;
    logic [7:0] dir_reg;
    logic [2:0] ctrl_latch_reg;
    logic [2:0] ctrl_dir_reg;
    logic       mode_reg;
    logic [5:0] analog_reg;
    logic       irq_en_reg;
    logic       irq_prio_reg;
    logic       pwm_busy_reg;
    logic       in_full_reg;
    logic       out_full_reg;
    logic       in_ovf_reg;
    logic       irq_flag_reg;
    logic       wr_act_reg;
    logic       rd_act_reg;
    logic [7:0] rdata_reg;
    logic       irq_reg;

    pcp_req_t     req;
    pcp_strobes_t strb;

    assign req  = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};
    assign strb = '{cs_n: ctl_lvl_reg[2], wr_n: ctl_lvl_reg[1], rd_n: ctl_lvl_reg[0]};

    // Address decode helper, used by every register write.
    function automatic logic hit(input pcp_req_t r, input logic [3:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction

    // Client mode needs the mode bit, no multi-output PWM, inputs on the
    // control pins and a digital pin configuration.
    wire analog_ok   = (analog_reg[3:0] >= PCP_ANALOG_DIGITAL_MIN);            // R5
    wire client_on   = mode_reg && !pwm_busy_reg                               // R1
                       && (ctrl_dir_reg == PCP_RST_CTRL_DIR) && analog_ok;     // R4 R3
    wire wr_window   = client_on && !strb.cs_n && !strb.wr_n;                  // R7
    wire rd_window   = client_on && !strb.cs_n && !strb.rd_n;                  // R9
    wire wr_end      = wr_act_reg && !wr_window;                               // R7
    wire rd_start    = rd_window && !rd_act_reg;                               // R9
    wire rd_end      = rd_act_reg && !rd_window;                               // R11
    wire sw_latch_wr = hit(req, PCP_OFS_DATA_LATCH) || hit(req, PCP_OFS_DATA_PINS);
    wire sw_in_read  = req.rd && (req.addr == PCP_OFS_DATA_PINS) && client_on;
    wire ctl_wr      = hit(req, PCP_OFS_CLIENT_CTL);
    wire flag_wr     = hit(req, PCP_OFS_IRQ_FLAGS);
    wire irq_event   = wr_end || rd_end;                                       // R8 R11
    // Next flag and enable, so the output follows a clear or a mask change at once.
    wire irq_flag_next = irq_event
                         || (irq_flag_reg && !(flag_wr && req.wdata[PCP_BIT_CLIENT_IRQ]));
    wire irq_en_next   = hit(req, PCP_OFS_IRQ_EN) ? req.wdata[PCP_BIT_CLIENT_IRQ] : irq_en_reg;

    // Software writable configuration.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_reg        <= PCP_RST_DATA_DIR;
            ctrl_latch_reg <= 3'h0;
            ctrl_dir_reg   <= PCP_RST_CTRL_DIR;
            mode_reg       <= 1'b0;
            analog_reg     <= 6'h00;
            irq_en_reg     <= 1'b0;
            irq_prio_reg   <= 1'b1;
            pwm_busy_reg   <= 1'b0;
        end else begin
            if (hit(req, PCP_OFS_DATA_DIR)) dir_reg <= req.wdata;
            if (hit(req, PCP_OFS_CTRL_LATCH) || hit(req, PCP_OFS_CTRL_PINS)) begin
                ctrl_latch_reg <= req.wdata[2:0];
            end
            if (ctl_wr) begin
                ctrl_dir_reg <= req.wdata[2:0];
                mode_reg     <= req.wdata[PCP_BIT_MODE];
            end
            if (hit(req, PCP_OFS_ANALOG_CFG)) analog_reg <= req.wdata[5:0];
            if (hit(req, PCP_OFS_IRQ_EN)) irq_en_reg <= req.wdata[PCP_BIT_CLIENT_IRQ];
            if (hit(req, PCP_OFS_IRQ_PRIO)) irq_prio_reg <= req.wdata[PCP_BIT_CLIENT_IRQ];
            if (hit(req, PCP_OFS_PWM_MODE)) pwm_busy_reg <= req.wdata[0];
        end
    end

    // ========================================================================
    // Transfer tracking and data latch
    // ========================================================================
    // The latch takes external writes at the end of the write window, so a
    // slow master's data has settled; an external write that ends in the
    // same cycle as a software write wins over it.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg  <= PCP_RST_ZERO;
            wr_act_reg <= 1'b0;
            rd_act_reg <= 1'b0;
        end else begin
            wr_act_reg <= wr_window;                   // R7
            rd_act_reg <= rd_window;                   // R9
            if (wr_end) begin
                latch_reg <= din_lvl_reg;              // R2
            end else if (sw_latch_wr) begin
                latch_reg <= req.wdata;                // R10
            end
        end
    end

    // Status flags; a hardware set or clear wins over a software action in the same cycle.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_full_reg  <= 1'b0;
            out_full_reg <= 1'b0;
            in_ovf_reg   <= 1'b0;
            irq_flag_reg <= 1'b0;
        end else begin
            if (wr_end) begin
                in_full_reg <= 1'b1;                   // R8 R13
            end else if (sw_in_read) begin
                in_full_reg <= 1'b0;                   // R13
            end
            if (rd_start || rd_act_reg) begin
                out_full_reg <= 1'b0;                  // R9 R10 R14
            end else if (sw_latch_wr) begin
                out_full_reg <= 1'b1;                  // R14
            end
            if (wr_end && in_full_reg) begin
                in_ovf_reg <= 1'b1;                    // R15
            end else if (ctl_wr && !req.wdata[PCP_BIT_IN_OVF]) begin
                in_ovf_reg <= 1'b0;                    // R15
            end
            if (irq_event) begin
                irq_flag_reg <= 1'b1;                  // R12
            end else if (flag_wr && req.wdata[PCP_BIT_CLIENT_IRQ]) begin
                irq_flag_reg <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Pin drive, read port and interrupt
    // ========================================================================
    wire [7:0] data_oe_next = rd_window ? 8'hFF                                // R9
                            : client_on ? 8'h00                                // R11
                            : ~dir_reg;
    wire [7:0] pins_now = (data_oe_next & latch_reg) | (~data_oe_next & din_lvl_reg);
    wire [7:0] ctl_stat = {in_full_reg, out_full_reg, in_ovf_reg, mode_reg,
                           1'b0, ctrl_dir_reg};
    wire [7:0] rdata_next =
        (req.addr == PCP_OFS_DATA_LATCH) ? latch_reg :
        (req.addr == PCP_OFS_DATA_PINS)  ? (client_on ? latch_reg : pins_now) :
        (req.addr == PCP_OFS_DATA_DIR)   ? dir_reg :
        (req.addr == PCP_OFS_CTRL_PINS)  ? {5'h00, ctl_lvl_reg} :
        (req.addr == PCP_OFS_CTRL_LATCH) ? {5'h00, ctrl_latch_reg} :
        (req.addr == PCP_OFS_CLIENT_CTL) ? ctl_stat :
        (req.addr == PCP_OFS_ANALOG_CFG) ? {2'h0, analog_reg} :
        (req.addr == PCP_OFS_IRQ_FLAGS)  ? {irq_flag_reg, 7'h00} :
        (req.addr == PCP_OFS_IRQ_EN)     ? {irq_en_reg, 7'h00} :
        (req.addr == PCP_OFS_IRQ_PRIO)   ? {irq_prio_reg, 7'h00} :
        (req.addr == PCP_OFS_PWM_MODE)   ? {7'h00, pwm_busy_reg} : 8'h00;

    // Outputs are registered; read data stands only in the cycle after the strobe.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg   <= 8'h00;
            irq_reg     <= 1'b0;
            o_data_pins <= 8'h00;
            o_data_oe   <= 8'h00;
            o_ctrl_pins <= 3'h0;
            o_ctrl_oe   <= 3'h0;
        end else begin
            rdata_reg   <= req.rd ? rdata_next : 8'h00;
            irq_reg     <= irq_flag_next && irq_en_next;                   // R12
            o_data_pins <= sw_latch_wr ? req.wdata : latch_reg;  // R10
            o_data_oe   <= data_oe_next;
            o_ctrl_pins <= ctrl_latch_reg;
            o_ctrl_oe   <= client_on ? 3'h0 : ~ctrl_dir_reg;     // R3
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_irq       = irq_reg;

endmodule

`default_nettype wire

// file: hdl/pcp_pkg.sv
// Package with register map, field positions and types of the parallel client port.
package pcp_pkg;

    // ========================================================================
    // Register offsets (word index on the plain register port)
    // ========================================================================
    localparam logic [3:0] PCP_OFS_DATA_LATCH = 4'h0;  // parallel_data_latch
    localparam logic [3:0] PCP_OFS_DATA_PINS  = 4'h1;  // parallel_data_pins
    localparam logic [3:0] PCP_OFS_DATA_DIR   = 4'h2;  // data_pin_direction
    localparam logic [3:0] PCP_OFS_CTRL_PINS  = 4'h3;  // control_pin_levels
    localparam logic [3:0] PCP_OFS_CTRL_LATCH = 4'h4;  // control_pin_latch
    localparam logic [3:0] PCP_OFS_CLIENT_CTL = 4'h5;  // client_port_control_status
    localparam logic [3:0] PCP_OFS_ANALOG_CFG = 4'h6;  // analog_pin_config
    localparam logic [3:0] PCP_OFS_IRQ_FLAGS  = 4'h7;  // peripheral_flags_one
    localparam logic [3:0] PCP_OFS_IRQ_EN     = 4'h8;  // peripheral_enables_one
    localparam logic [3:0] PCP_OFS_IRQ_PRIO   = 4'h9;  // peripheral_priority_one
    localparam logic [3:0] PCP_OFS_PWM_MODE   = 4'hA;  // multi-output PWM busy level

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int PCP_BIT_IN_FULL   = 7;
    localparam int PCP_BIT_OUT_FULL  = 6;
    localparam int PCP_BIT_IN_OVF    = 5;
    localparam int PCP_BIT_MODE      = 4;
    localparam int PCP_BIT_CLIENT_IRQ = 7;
    localparam logic [3:0] PCP_ANALOG_DIGITAL_MIN = 4'hA;  // 1010 .. 1111

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [7:0] PCP_RST_DATA_DIR   = 8'hFF;
    localparam logic [2:0] PCP_RST_CTRL_DIR   = 3'h7;
    localparam logic [7:0] PCP_RST_ZERO       = 8'h00;

    // Synchronised control strobes, all active low.
    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
    } pcp_strobes_t;

    // Register bus request.
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pcp_req_t;

endpackage

// file: verif/pcp_ext_master.sv
// Model of the external microprocessor on the client port data bus.
`timescale 1ns/1ps
`default_nettype none
module pcp_ext_master (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_dev_data,
    input  wire logic [7:0] i_dev_oe,
    output logic      [7:0] o_bus,
    output logic      [2:0] o_ctrl
);
    logic [7:0] drv_reg;
    logic       drv_en_reg;
    // The bus has no pull, so a released bus shows the inverse of the last byte.
    assign o_bus = (i_dev_oe & i_dev_data) | (~i_dev_oe & (drv_en_reg ? drv_reg : ~drv_reg));
    initial begin
        o_ctrl = 3'h7;
        drv_reg = 8'h00;
        drv_en_reg = 1'b0;
    end
    // Select and write strobe fall together; data is held well past their rise.
    task automatic ext_write(input logic [7:0] d);
        @(posedge i_clk);
        o_ctrl <= 3'h1;
        drv_reg <= d;
        drv_en_reg <= 1'b1;
        repeat (6) @(posedge i_clk);
        o_ctrl <= 3'h7;
        repeat (6) @(posedge i_clk);
        drv_en_reg <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask
    // Select and read strobe fall together and stay low until the stop call.
    task automatic rd_start();
        @(posedge i_clk);
        o_ctrl <= 3'h2;
        repeat (8) @(posedge i_clk);
    endtask
    task automatic rd_sample(output logic [7:0] d);
        repeat (2) @(posedge i_clk);
        #1 d = o_bus;
    endtask
    task automatic rd_stop();
        @(posedge i_clk);
        o_ctrl <= 3'h7;
        repeat (8) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// file: verif/pcp_monitor.sv
// Assertion checker of the parallel client port, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module pcp_monitor (
    input wire logic       i_clk,
    input wire logic       i_resetn,
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [7:0] o_data_oe,
    input wire logic [2:0] i_ctrl_pins,
    input wire logic [2:0] o_ctrl_oe,
    input wire logic       o_irq
);
    // ========================================
    // Shadow of the mode set-up and strobe low counters.
    logic [7:0] ctl_reg;
    logic [3:0] ana_reg;
    logic       pwm_reg;
    logic       en_reg;
    logic [3:0] lw_reg;
    logic [3:0] lr_reg;
    wire        wr_low = !i_ctrl_pins[2] && !i_ctrl_pins[1];
    wire        rd_low = !i_ctrl_pins[2] && !i_ctrl_pins[0];
    wire        mode_ok = ctl_reg[4] && ctl_reg[2:0] == 3'h7 && ana_reg >= 4'hA && !pwm_reg;
    wire        wr_end = mode_ok && en_reg && lw_reg >= 4'h6 && !wr_low;
    wire        rd_end = mode_ok && en_reg && lr_reg >= 4'h6 && !rd_low;
    // Counters saturate so that a long strobe never wraps back to a short one.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctl_reg <= 8'h07;
            ana_reg <= 4'h0;
            pwm_reg <= 1'b0;
            en_reg  <= 1'b0;
            lw_reg  <= 4'h0;
            lr_reg  <= 4'h0;
        end else begin
            if (i_reg_wr && i_reg_addr == 4'h5) ctl_reg <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == 4'h6) ana_reg <= i_reg_wdata[3:0];
            if (i_reg_wr && i_reg_addr == 4'hA) pwm_reg <= i_reg_wdata[0];
            if (i_reg_wr && i_reg_addr == 4'h8) en_reg <= i_reg_wdata[7];
            lw_reg <= !wr_low ? 4'h0 : (lw_reg == 4'hF) ? lw_reg : lw_reg + 4'h1;
            lr_reg <= !rd_low ? 4'h0 : (lr_reg == 4'hF) ? lr_reg : lr_reg + 4'h1;
        end
    end
    // ========================================
    // Properties.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    AST_RDATA_IDLE: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
        else $error("read data not zero outside its slot");
    AST_READ_DRIVE: assert property (mode_ok && lr_reg >= 4'h8 |-> o_data_oe == 8'hFF)
        else $error("data pins not driven during external read");
    AST_READ_HOLD: assert property (mode_ok && lr_reg != 4'h0 && o_data_oe == 8'hFF |=> o_data_oe == 8'hFF)
        else $error("data drive dropped inside read");
    AST_READ_RELEASE: assert property ((mode_ok && !rd_low)[*8] |-> o_data_oe == 8'h00)
        else $error("data pins still driven after read");
    AST_CTRL_INPUT: assert property (mode_ok[*3] |-> o_ctrl_oe == 3'h0)
        else $error("control pins driven in client mode");
    AST_WRITE_IRQ: assert property (wr_end |-> ##[1:10] o_irq)
        else $error("no interrupt after external write");
    AST_READ_IRQ: assert property (rd_end |-> ##[1:10] o_irq)
        else $error("no interrupt after external read");
    AST_GPIO_QUIET: assert property ((!mode_ok && en_reg)[*8] |-> !$rose(o_irq))
        else $error("interrupt raised outside client mode");
    AST_IRQ_MASKED: assert property (!en_reg |-> !o_irq)
        else $error("interrupt raised while masked");
    COV_WRITE: cover property (wr_end);
    COV_READ: cover property (rd_end);
    COV_REFUSED: cover property (!mode_ok && lw_reg == 4'h6);
endmodule
bind pcp_client_port pcp_monitor u_mon (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_data_oe(o_data_oe),
    .i_ctrl_pins(i_ctrl_pins), .o_ctrl_oe(o_ctrl_oe), .o_irq(o_irq));
`default_nettype wire

// file: verif/testbench.sv
// Self-checking testbench of the parallel client port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pcp_pkg::*;
    logic       i_clk;
    logic       i_resetn;
    pcp_req_t   req;
    logic [7:0] w_rdata, w_dout, w_doe, w_bus, v, d;
    logic [2:0] w_ctrl, w_clat, w_coe, w_cpin;
    logic       w_irq;
    logic [16:0] seed;
    int         fails, n_tests;
    // Control pins resolve the device drive against the external master.
    assign w_cpin = (w_coe & w_clat) | (~w_coe & w_ctrl);
    pcp_client_port DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_reg_addr(req.addr),
        .i_reg_wdata(req.wdata), .i_reg_wr(req.wr), .i_reg_rd(req.rd), .o_reg_rdata(w_rdata),
        .i_data_pins(w_bus), .o_data_pins(w_dout), .o_data_oe(w_doe), .i_ctrl_pins(w_cpin),
        .o_ctrl_pins(w_clat), .o_ctrl_oe(w_coe), .o_irq(w_irq));
    pcp_ext_master u_ext (.i_clk(i_clk), .i_dev_data(w_dout), .i_dev_oe(w_doe),
        .o_bus(w_bus), .o_ctrl(w_ctrl));
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    // Expected status register in client mode with all control pins as inputs.
    function automatic logic [7:0] stat(input logic inf, input logic outf, input logic ovf);
        return {inf, outf, ovf, 5'h17};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rw(input logic [3:0] a, input logic [7:0] wd);
        @(posedge i_clk);
        req.addr <= a;
        req.wdata <= wd;
        req.wr <= 1'b1;
        @(posedge i_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rr(input logic [3:0] a, output logic [7:0] rd);
        @(posedge i_clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge i_clk);
        req.rd <= 1'b0;
        #1 rd = w_rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] x;
        rr(a, x);
        check(x & m, exp);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // A hang is cut short well beyond the few hundred cycles the run needs.
    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        wrap_up();
    end
    initial begin
        i_resetn = 1'b0;
        req = '0;
        fails = 0;
        n_tests = 0;
        seed = 17'h180CD;
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_clk);
        rchk(4'h2, 8'hFF, 8'hFF);
        rchk(4'h5, 8'hFF, 8'h07);
        rchk(4'hF, 8'hFF, 8'h00);
        rchk(4'h9, 8'hFF, 8'h80);
        rw(4'h8, 8'h80);
        // Busy PWM, a bad analog field, a control pin as output: writes ignored.
        for (int i = 0; i < 3; i++) begin
            rw(4'hA, {7'h0, i == 0});
            rw(4'h6, (i == 1) ? 8'h09 : 8'h0F);
            rw(4'h5, (i == 2) ? 8'h16 : 8'h17);
            u_ext.ext_write(8'h5A);
            rchk(4'h5, 8'h80, 8'h00);
            check({7'h0, w_irq}, 8'h00);
        end
        // Direction 110 leaves pin zero an output that shows the control latch.
        rw(4'h4, 8'h05);
        rchk(4'h4, 8'hFF, 8'h05);
        check({5'h00, w_clat}, 8'h05);
        check({5'h00, w_coe}, 8'h01);
        $display("test refused modes done");
        rw(4'hA, 8'h00);
        rw(4'h6, 8'h0A + 8'(seed % 6));
        rw(4'h5, 8'h17);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            d = seed[7:0];
            u_ext.ext_write(d);
            check({7'h0, w_irq}, 8'h01);
            rchk(4'h5, 8'hFF, stat(1'b1, 1'b0, 1'b0));
            rchk(4'h0, 8'hFF, d);
            rr(4'h1, v);
            rchk(4'h5, 8'hFF, stat(1'b0, 1'b0, 1'b0));
            rw(4'h7, 8'h80);
        end
        $display("test external writes done");
        // Second write before software read: overflow is sticky until cleared.
        u_ext.ext_write(8'h11);
        u_ext.ext_write(8'hEE);
        rchk(4'h5, 8'hFF, stat(1'b1, 1'b0, 1'b1));
        rr(4'h1, v);
        rchk(4'h5, 8'hFF, stat(1'b0, 1'b0, 1'b1));
        rw(4'h5, 8'h17);
        rchk(4'h5, 8'hFF, stat(1'b0, 1'b0, 1'b0));
        rw(4'h8, 8'h00);
        rchk(4'h7, 8'h80, 8'h80);
        check({7'h0, w_irq}, 8'h00);
        rw(4'h8, 8'h80);
        rr(4'h7, v);
        check({7'h0, w_irq}, 8'h01);
        rw(4'h7, 8'h80);
        rr(4'h7, v);
        check({7'h0, w_irq}, 8'h00);
        $display("test overflow and mask done");
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            rw(4'h0, seed[7:0]);
            rchk(4'h5, 8'hFF, stat(1'b0, 1'b1, 1'b0));
            u_ext.rd_start();
            u_ext.rd_sample(v);
            check(v, seed[7:0]);
            rw(4'h0, ~seed[7:0]);
            u_ext.rd_sample(v);
            check(v, ~seed[7:0]);
            rchk(4'h5, 8'hFF, stat(1'b0, 1'b0, 1'b0));
            u_ext.rd_stop();
            check(w_doe, 8'h00);
            check({7'h0, w_irq}, 8'h01);
            rw(4'h7, 8'h80);
        end
        $display("test external reads done");
        wrap_up();
    end
endmodule
`default_nettype wire
